// *** tie_map.vh ***
// Constants for the transfer instruction execution block.
// Assumes inclusion by tie_exec.v, the checker and the bench; tie_mem_port.v does not include it.
`ifndef TIE_MAP_VH
`define TIE_MAP_VH
// Operation codes on opCode
`define TIE_OP_NONE     4'h0
`define TIE_OP_CTX      4'h1
`define TIE_OP_EXTLOAD  4'h2
`define TIE_OP_VECBASE  4'h3
`define TIE_OP_PRILVL   4'h4
`define TIE_OP_MOVE     4'h5
// Move formats
`define TIE_FMT_G       2'h0
`define TIE_FMT_Q       2'h1
`define TIE_FMT_S       2'h2
`define TIE_FMT_Z       2'h3
// Operand kinds
`define TIE_OPD_REG     3'h0
`define TIE_OPD_MEM     3'h1
`define TIE_OPD_IMM     3'h2
`define TIE_OPD_SPREL   3'h3
`define TIE_OPD_DSP20   3'h4
`define TIE_OPD_ABSOLUTE_LONG_ADDRESS   3'h5
`define TIE_OPD_PAIR    3'h6
// Register numbers
`define TIE_REG_ACC_LO  3'h0
`define TIE_REG_ACC_HI  3'h1
`define TIE_REG_LOADR   3'h4
`define TIE_REG_HIADR   3'h5
// Flag register bit positions
`define TIE_FLG_Z       1
`define TIE_FLG_S       3
`define TIE_FLG_U       7
// Priority level field
`define TIE_IPL_MAX     3'h7
`define TIE_IPL_RST     3'h0
// Reset values
`define TIE_VEC_RST     20'h00000
`define TIE_FLG_RST     8'h00
`endif

// *** tie_mem_port.v ***
// Single-request memory port with two-cycle read answer.
// Assumes memory accepts every request and answers reads next cycle.
`timescale 1ns/100ps
`default_nettype none
module tie_mem_port
#(
  parameter AW = 20
)
(
  // Clock and reset
  input  wire          clk,
  input  wire          reset_n,
  // Request from sequencer
  input  wire          reqRead,
  input  wire          reqWrite,
  input  wire [AW-1:0] reqAddr,
  input  wire [15:0]   reqWdata,
  input  wire          reqWord,
  // Memory pins
  output reg           memRead,
  output reg           memWrite,
  output reg  [AW-1:0] memAddr,
  output reg  [15:0]   memWdata,
  output reg           memWord,
  input  wire [15:0]   memRdata,
  // Answer
  output reg           ansValid,
  output wire [15:0]   ansData
);
  // ----------------------------------------
  // Registered request, answer flag
  // ----------------------------------------
  reg pendRead_reg;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memRead      <= 1'b0;
      memWrite     <= 1'b0;
      memAddr      <= {AW{1'b0}};
      memWdata     <= 16'h0000;
      memWord      <= 1'b0;
      pendRead_reg <= 1'b0;
      ansValid     <= 1'b0;
    end
    else
    begin
      memRead      <= reqRead;
      memWrite     <= reqWrite;
      memAddr      <= reqAddr;
      memWdata     <= reqWdata;
      memWord      <= reqWord;
      pendRead_reg <= reqRead;
      ansValid     <= pendRead_reg; // Data sampled two edges after request
    end
  end
  // Memory drives read data in the very cycle ansValid stands;
  // a register here would catch the bus one cycle too early
  assign ansData = memRdata;
endmodule // tie_mem_port
`default_nettype wire

// *** tie_exec.v ***
// Execution unit for context restore, extended load, vector-base load,
// priority-level load and the general move. Expects one decoded op per
// start pulse, legal operand combinations, and a memory answering reads.
//
// Behaviour
// - Context restore takes short task-number address and long table base.
// - Selection byte at base plus twice task number, correction next.
// - Selected registers load from successive stack data, others kept.
// - Stack pointer gets correction value added after restoring.
// - Extended load source: long displacement, long absolute, or pair.
// - Byte load into address register zero-extends to 16 bits.
// - Extended load and move set sign and zero flags only.
// - Vector base loads 20-bit immediate, high part then low part.
// - Priority level field gets immediate; software keeps it 0..7.
// - Byte move from address register uses its low 8 bits.
// - Stack-relative operands use selected stack pointer; never both sides.
// - Quick format immediate is a signed 4-bit value, -8..+7.
// - Short format accumulator low to high address reg, high to low.
// - Vector halves loaded back to back; no interrupt after control load.
`timescale 1ns/100ps
`default_nettype none
`include "tie_map.vh"
module tie_exec
#(
  parameter AW = 20
)
(
  // Clock and reset
  input  wire          clk,
  input  wire          reset_n,
  // Decoded instruction
  input  wire          start,
  input  wire [3:0]    opCode,
  input  wire [1:0]    moveFormat,
  input  wire          sizeWord,
  input  wire [2:0]    srcKind,
  input  wire [2:0]    srcReg,
  input  wire [2:0]    dstKind,
  input  wire [2:0]    dstReg,
  input  wire [19:0]   operandA,
  input  wire [15:0]   operandB,
  input  wire [15:0]   srcRegData,
  input  wire [15:0]   loAddrRegData,
  input  wire [15:0]   hiAddrRegData,
  input  wire [15:0]   userSp,
  input  wire [15:0]   intSp,
  input  wire [7:0]    flagsIn,
  // Memory pins
  output wire          memRead,
  output wire          memWrite,
  output wire [AW-1:0] memAddr,
  output wire [15:0]   memWdata,
  output wire          memWord,
  input  wire [15:0]   memRdata,
  // Register file write
  output reg           regWrite,
  output reg  [2:0]    regSel,
  output reg  [15:0]   regWdata,
  output reg           regWordWrite,
  output reg           spWrite,
  output reg  [15:0]   spWdata,
  // Control registers and flags
  output reg  [19:0]   vectorTableBase,
  output reg  [2:0]    interruptPriorityLevel,
  output reg           flagsWrite,
  output reg  [7:0]    flagsOut,
  output reg           irqBlock,
  output reg           busy
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE   = 3'h0;
  localparam ST_TASK   = 3'h1;
  localparam ST_TABLE  = 3'h2;
  localparam ST_POP    = 3'h3;
  localparam ST_SRC    = 3'h4;
  localparam ST_VECLO  = 3'h5;
  localparam ST_FINISH = 3'h6;
  localparam ST_WRITE  = 3'h7;

  reg  [2:0]  state_reg;
  reg  [7:0]  selMask_reg;
  reg  [15:0] spCorr_reg;
  reg  [15:0] popPtr_reg;
  reg  [2:0]  popIdx_reg;
  reg  [19:0] tableBase_reg;
  reg  [19:0] vecImm_reg;
  reg         waitAns_reg;
  reg         sizeWord_reg;
  reg  [2:0]  dstKind_reg;
  reg  [2:0]  dstReg_reg;
  reg  [15:0] dstAddr_reg;
  reg  [15:0] result_reg;

  // Memory request
  reg          reqRead;
  reg          reqWrite;
  reg [AW-1:0] reqAddr;
  reg [15:0]   reqWdata;
  reg          reqWord;
  wire         ansValid;
  wire [15:0]  ansData;

  tie_mem_port #(.AW(AW)) memPort
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .reqRead  (reqRead),
    .reqWrite (reqWrite),
    .reqAddr  (reqAddr),
    .reqWdata (reqWdata),
    .reqWord  (reqWord),
    .memRead  (memRead),
    .memWrite (memWrite),
    .memAddr  (memAddr),
    .memWdata (memWdata),
    .memWord  (memWord),
    .memRdata (memRdata),
    .ansValid (ansValid),
    .ansData  (ansData)
  );

  // ----------------------------------------
  // Operand helpers
  // ----------------------------------------
  // Stack-relative base follows the stack-select flag
  wire [15:0] activeSp = flagsIn[`TIE_FLG_U] ? userSp : intSp;
  // Quick immediate: signed 4-bit sign-extended
  wire [15:0] quickImm = {{12{operandB[3]}}, operandB[3:0]};
  // Extended source address, only three modes
  reg  [19:0] extAddr;
  always @*
  begin
    case (srcKind)
      `TIE_OPD_DSP20: extAddr = operandA + {4'h0, loAddrRegData};
      `TIE_OPD_PAIR:  extAddr = {hiAddrRegData[3:0], loAddrRegData};
      default:        extAddr = operandA;
    endcase
  end
  // Short-format address-register target forced by accumulator half
  wire [2:0] shortDst = (srcReg == `TIE_REG_ACC_LO) ? `TIE_REG_HIADR
                                                  : `TIE_REG_LOADR;
  wire shortAccToAdr = (moveFormat == `TIE_FMT_S) && (srcKind == `TIE_OPD_REG)
                       && (dstKind == `TIE_OPD_REG) && dstReg[2];

  // Move source value, byte from address reg uses low 8 bits
  reg [15:0] moveSrc;
  always @*
  begin
    case (moveFormat)
      `TIE_FMT_Q: moveSrc = quickImm;
      `TIE_FMT_Z: moveSrc = 16'h0000;
      default:
        if (srcKind == `TIE_OPD_IMM)
          moveSrc = operandB;
        else if (!sizeWord)
          moveSrc = {8'h00, srcRegData[7:0]};
        else
          moveSrc = srcRegData;
    endcase
  end

  // Result shaping: byte into an address register is written as 16 bits
  wire        resultWide = sizeWord_reg ||
                           (dstKind_reg == `TIE_OPD_REG && dstReg_reg[2]);
  wire [15:0] resultVal  = sizeWord_reg ? result_reg
                                        : {8'h00, result_reg[7:0]};

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg              <= ST_IDLE;
      selMask_reg            <= 8'h00;
      spCorr_reg             <= 16'h0000;
      popPtr_reg             <= 16'h0000;
      popIdx_reg             <= 3'h0;
      tableBase_reg          <= 20'h00000;
      vecImm_reg             <= 20'h00000;
      waitAns_reg            <= 1'b0;
      sizeWord_reg           <= 1'b0;
      dstKind_reg            <= 3'h0;
      dstReg_reg             <= 3'h0;
      dstAddr_reg            <= 16'h0000;
      result_reg             <= 16'h0000;
      regWrite               <= 1'b0;
      regSel                 <= 3'h0;
      regWdata               <= 16'h0000;
      regWordWrite           <= 1'b0;
      spWrite                <= 1'b0;
      spWdata                <= 16'h0000;
      vectorTableBase        <= `TIE_VEC_RST;
      interruptPriorityLevel <= `TIE_IPL_RST;
      flagsWrite             <= 1'b0;
      flagsOut               <= `TIE_FLG_RST;
      irqBlock               <= 1'b0;
      busy                   <= 1'b0;
    end
    else
    begin
      regWrite   <= 1'b0;
      spWrite    <= 1'b0;
      flagsWrite <= 1'b0;
      irqBlock   <= 1'b0;
      case (state_reg)
        ST_IDLE:
          if (start)
          begin
            busy         <= 1'b1;
            sizeWord_reg <= sizeWord;
            dstKind_reg  <= dstKind;
            dstReg_reg   <= shortAccToAdr ? shortDst : dstReg;
            dstAddr_reg  <= (dstKind == `TIE_OPD_SPREL)
                            ? activeSp + operandB : operandB;
            case (opCode)
              `TIE_OP_CTX:
              begin
                tableBase_reg <= operandA;
                waitAns_reg   <= 1'b1;
                state_reg     <= ST_TASK;
              end
              `TIE_OP_EXTLOAD:
              begin
                waitAns_reg <= 1'b1;
                state_reg   <= ST_SRC;
              end
              `TIE_OP_VECBASE:
              begin
                // High part lands first, low part next cycle
                vectorTableBase[19:16] <= operandA[19:16];
                vecImm_reg             <= operandA;
                irqBlock               <= 1'b1;
                state_reg              <= ST_VECLO;
              end
              `TIE_OP_PRILVL:
              begin
                // Only 3 bits held; values above 7 are the program's fault
                interruptPriorityLevel <= operandB[2:0];
                irqBlock               <= 1'b1;
                state_reg              <= ST_FINISH;
              end
              `TIE_OP_MOVE:
                if (srcKind == `TIE_OPD_MEM || srcKind == `TIE_OPD_SPREL)
                begin
                  waitAns_reg <= 1'b1;
                  state_reg   <= ST_SRC;
                end
                else
                begin
                  result_reg <= moveSrc;
                  state_reg  <= ST_WRITE;
                end
              default:
                state_reg <= ST_FINISH;
            endcase
          end
        ST_TASK:
          if (ansValid)
            state_reg <= ST_TABLE;
        ST_TABLE:
          if (ansValid)
          begin
            selMask_reg <= ansData[7:0];
            spCorr_reg  <= {8'h00, ansData[15:8]};
            popPtr_reg  <= activeSp;
            popIdx_reg  <= 3'h0;
            waitAns_reg <= 1'b0;
            state_reg   <= ST_POP;
          end
        ST_POP:
          if (!selMask_reg[popIdx_reg])
          begin
            // Unselected register keeps its value
            popIdx_reg <= popIdx_reg + 3'h1;
            if (popIdx_reg == 3'h7)
              state_reg <= ST_FINISH;
          end
          else if (ansValid)
          begin
            regWrite     <= 1'b1;
            regSel       <= popIdx_reg;
            regWdata     <= ansData;
            regWordWrite <= 1'b1;
            popPtr_reg   <= popPtr_reg + 16'h0002;
            popIdx_reg   <= popIdx_reg + 3'h1;
            waitAns_reg  <= 1'b0;
            if (popIdx_reg == 3'h7)
              state_reg <= ST_FINISH;
          end
          else
            waitAns_reg <= 1'b1;
        ST_SRC:
          if (ansValid)
          begin
            waitAns_reg <= 1'b0;
            result_reg  <= ansData;
            state_reg   <= ST_WRITE;
          end
        ST_WRITE:
        begin
          // Register target here; memory target goes out on the request port
          if (dstKind_reg == `TIE_OPD_REG)
          begin
            regWrite     <= 1'b1;
            regSel       <= dstReg_reg;
            regWdata     <= resultVal;
            regWordWrite <= resultWide;
          end
          flagsWrite           <= 1'b1;
          flagsOut             <= flagsIn;
          flagsOut[`TIE_FLG_S] <= resultWide ? resultVal[15] : resultVal[7];
          flagsOut[`TIE_FLG_Z] <= resultWide ? (resultVal == 16'h0000)
                                             : (resultVal[7:0] == 8'h00);
          state_reg            <= ST_FINISH;
        end
        ST_VECLO:
        begin
          vectorTableBase[15:0] <= vecImm_reg[15:0];
          irqBlock              <= 1'b1;
          state_reg             <= ST_FINISH;
        end
        ST_FINISH:
        begin
          if (opCode == `TIE_OP_CTX && busy)
          begin
            spWrite <= 1'b1;
            spWdata <= activeSp + spCorr_reg;
          end
          busy      <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Memory requests and result writes
  // ----------------------------------------
  always @*
  begin
    reqRead  = 1'b0;
    reqWrite = 1'b0;
    reqAddr  = {AW{1'b0}};
    reqWdata = 16'h0000;
    reqWord  = 1'b1;
    if (state_reg == ST_IDLE && start)
    begin
      if (opCode == `TIE_OP_CTX)
      begin
        reqRead = 1'b1;
        reqAddr = {4'h0, operandB};
      end
      else if (opCode == `TIE_OP_EXTLOAD)
      begin
        reqRead = 1'b1;
        reqAddr = extAddr;
        reqWord = sizeWord;
      end
      else if (opCode == `TIE_OP_MOVE && srcKind == `TIE_OPD_SPREL)
      begin
        reqRead = 1'b1;
        reqAddr = {4'h0, activeSp + operandA[15:0]};
        reqWord = sizeWord;
      end
      else if (opCode == `TIE_OP_MOVE && srcKind == `TIE_OPD_MEM)
      begin
        reqRead = 1'b1;
        reqAddr = operandA;
        reqWord = sizeWord;
      end
    end
    else if (state_reg == ST_TASK && ansValid)
    begin
      reqRead = 1'b1;
      reqAddr = tableBase_reg + {3'h0, ansData, 1'b0};
    end
    else if (state_reg == ST_POP && selMask_reg[popIdx_reg] && !waitAns_reg)
    begin
      reqRead = 1'b1;
      reqAddr = {4'h0, popPtr_reg};
    end
    else if (state_reg == ST_WRITE && dstKind_reg != `TIE_OPD_REG)
    begin
      reqWrite = 1'b1;
      reqAddr  = {4'h0, dstAddr_reg};
      reqWdata = resultVal;
      reqWord  = sizeWord_reg;
    end
  end
endmodule // tie_exec
`default_nettype wire

// *** tie_exec_sva.sv ***
// Checker for the transfer instruction execution block.
// Assumes one decoded op per start pulse and a registered busy flag.
`timescale 1ns/100ps
`default_nettype none
`include "tie_map.vh"
module tie_exec_sva
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Decoded instruction
  input wire logic        start,
  input wire logic [3:0]  opCode,
  input wire logic        sizeWord,
  input wire logic [19:0] operandA,
  input wire logic [15:0] operandB,
  input wire logic [7:0]  flagsIn,
  // Results
  input wire logic        regWrite,
  input wire logic [2:0]  regSel,
  input wire logic [15:0] regWdata,
  input wire logic        regWordWrite,
  input wire logic        spWrite,
  input wire logic [19:0] vectorTableBase,
  input wire logic [2:0]  interruptPriorityLevel,
  input wire logic        flagsWrite,
  input wire logic [7:0]  flagsOut,
  input wire logic        busy
);
  // ---------------------------------------------------------------
  // Op capture
  // ---------------------------------------------------------------
  logic [3:0]  curOp;
  logic [19:0] curA;
  logic [15:0] curB;
  logic        curWord;
  logic        ctlOp;
  logic        resOp;

  // Latch the op so results can be tied back to what was asked
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      curOp   <= `TIE_OP_NONE;
      curA    <= 20'h00000;
      curB    <= 16'h0000;
      curWord <= 1'b0;
    end
    else if (start)
    begin
      curOp   <= opCode;
      curA    <= operandA;
      curB    <= operandB;
      curWord <= sizeWord;
    end
  end

  // Ops that must leave flags alone versus ops that set sign and zero
  assign ctlOp = (curOp == `TIE_OP_CTX) || (curOp == `TIE_OP_VECBASE) ||
                 (curOp == `TIE_OP_PRILVL);
  assign resOp = (curOp == `TIE_OP_EXTLOAD) || (curOp == `TIE_OP_MOVE);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_vec_done;
    $fell(busy) && (curOp == `TIE_OP_VECBASE);
  endsequence
  sequence s_res_flag;
    regWrite && flagsWrite && resOp;
  endsequence

  a_ctl_flags_keep: assert property (flagsWrite && ctlOp |-> flagsOut == flagsIn)
    else $error("control op altered flags");
  a_other_flags_keep: assert property (flagsWrite |-> (flagsOut & 8'hf5) == (flagsIn & 8'hf5))
    else $error("flag other than sign or zero altered");
  a_zero_flag_set: assert property (s_res_flag |->
      flagsOut[`TIE_FLG_Z] == (regWordWrite ? regWdata == 16'h0000 : regWdata[7:0] == 8'h00))
    else $error("zero flag does not match result");
  a_sign_flag_set: assert property (s_res_flag |->
      flagsOut[`TIE_FLG_S] == (regWordWrite ? regWdata[15] : regWdata[7]))
    else $error("sign flag does not match result");
  a_byte_zero_ext: assert property (regWrite && resOp && !curWord &&
      (regSel == `TIE_REG_LOADR || regSel == `TIE_REG_HIADR) |->
      regWordWrite && regWdata[15:8] == 8'h00)
    else $error("byte into address register not zero extended");
  a_sp_ctx_only: assert property (spWrite |-> curOp == `TIE_OP_CTX)
    else $error("stack pointer written outside restore");
  a_vec_value_ok: assert property (s_vec_done |-> vectorTableBase == curA)
    else $error("vector base differs from immediate");
  a_vec_write_own: assert property (!$stable(vectorTableBase) |-> curOp == `TIE_OP_VECBASE)
    else $error("vector base changed by other op");
  a_ipl_write_own: assert property (!$stable(interruptPriorityLevel) |->
      curOp == `TIE_OP_PRILVL && interruptPriorityLevel == curB[2:0])
    else $error("priority level changed wrongly");
endmodule // tie_exec_sva
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the transfer instruction execution block.
// Assumes a one-cycle start pulse, busy while working, reads answered next cycle.
`timescale 1ns/100ps
`default_nettype none
`include "tie_map.vh"
module tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0, sizeWord = 1'b0;
  logic [3:0]  opCode = 4'h0;
  logic [1:0]  moveFormat = 2'h0;
  logic [2:0]  srcKind = 3'h0, srcReg = 3'h0, dstKind = 3'h0, dstReg = 3'h0;
  logic [19:0] operandA = 20'h00000, watchAddr = 20'h00000, lastAddr;
  logic [15:0] operandB = 16'h0000, srcRegData = 16'h0000, memRdata = 16'h0000;
  logic [15:0] loAddrRegData = 16'h0000, hiAddrRegData = 16'h0000;
  logic [15:0] userSp = 16'h0400, intSp = 16'h0400, lastData, lastSp;
  logic [7:0]  flagsIn = 8'h45, lastFlags;
  logic [15:0] memTab [bit [19:0]];
  logic        lastWord, sawAddr;
  logic [2:0]  lastSel;
  int          nReg, err_total = 0, n_compared = 0;
  wire         memRead, memWrite, memWord, regWrite, regWordWrite, spWrite;
  wire         flagsWrite, irqBlock, busy;
  wire [19:0]  memAddr, vectorTableBase;
  wire [15:0]  memWdata, regWdata, spWdata;
  wire [2:0]   regSel, interruptPriorityLevel;
  wire [7:0]   flagsOut;

  tie_exec u_tie_exec (.clk, .reset_n, .start, .opCode, .moveFormat, .sizeWord,
    .srcKind, .srcReg, .dstKind, .dstReg, .operandA, .operandB, .srcRegData,
    .loAddrRegData, .hiAddrRegData, .userSp, .intSp, .flagsIn, .memRead, .memWrite,
    .memAddr, .memWdata, .memWord, .memRdata, .regWrite, .regSel, .regWdata,
    .regWordWrite, .spWrite, .spWdata, .vectorTableBase, .interruptPriorityLevel,
    .flagsWrite, .flagsOut, .irqBlock, .busy);

  // ---------------------------------------------------------------
  // Clock, memory and result monitor
  // ---------------------------------------------------------------
  always #20 clk = ~clk;

  // Table entries first, else a pattern from the address
  function automatic logic [15:0] mem_rd(input logic [19:0] a);
    if (memTab.exists(a))
      return memTab[a];
    return a[15:0] ^ 16'h3c3c;
  endfunction

  // Idle data bus toggles so a stale value is never mistaken for an answer
  always @(posedge clk)
  begin
    memRdata <= memRead ? mem_rd(memAddr) : ~memRdata;
    if (start)
    begin
      nReg      <= 0;
      sawAddr   <= 1'b0;
      lastFlags <= flagsIn;
    end
    else
    begin
      if (regWrite)
      begin
        nReg     <= nReg + 1;
        lastData <= regWdata;
        lastWord <= regWordWrite;
        lastSel  <= regSel;
      end
      if (spWrite) lastSp <= spWdata;
      if (flagsWrite) lastFlags <= flagsOut;
      if (memRead) lastAddr <= memAddr;
      if (memRead && memAddr == watchAddr) sawAddr <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic prep(input logic [1:0] f, input logic w, input logic [2:0] sk,
                      input logic [2:0] sr, input logic [2:0] dk, input logic [2:0] dr,
                      input logic [19:0] a);
    moveFormat <= f; sizeWord <= w; srcKind <= sk; srcReg <= sr;
    dstKind <= dk; dstReg <= dr; operandA <= a; operandB <= a[15:0];
  endtask

  // Pulse start, then wait for busy to settle low under a bound
  task automatic go(input logic [3:0] op);
    int n;
    n = 0;
    opCode <= op;
    start  <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(negedge clk); while (busy !== 1'b0 && ++n < 500);
    if (n >= 500) check(1'b1, 1'b0);
    repeat (2) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_ctl;
    prep(`TIE_FMT_G, 1'b1, `TIE_OPD_IMM, 3'h0, `TIE_OPD_REG, 3'h0, 20'habcde);
    go(`TIE_OP_VECBASE);
    check(vectorTableBase, 20'habcde);
    check(lastFlags, flagsIn);
    prep(`TIE_FMT_G, 1'b0, `TIE_OPD_IMM, 3'h0, `TIE_OPD_REG, 3'h0, 20'h00007);
    go(`TIE_OP_PRILVL);
    check(interruptPriorityLevel, 3'h7);
    check(lastFlags, flagsIn);
    $display("test control loads done");
  endtask

  // Byte from address register, short-format forced target, quick immediates
  // Never a byte move between address registers
  // Never an immediate into a stack-relative destination
  // Short format only with byte size and distinct registers
  task automatic t_move;
    srcRegData    <= 16'h1280;
    loAddrRegData <= 16'h1280;
    prep(`TIE_FMT_G, 1'b0, `TIE_OPD_REG, `TIE_REG_LOADR, `TIE_OPD_REG, `TIE_REG_ACC_LO, 0);
    go(`TIE_OP_MOVE);
    check(lastData[7:0], 8'h80);
    check(lastFlags, 8'h4d);
    prep(`TIE_FMT_S, 1'b0, `TIE_OPD_REG, `TIE_REG_ACC_LO, `TIE_OPD_REG, `TIE_REG_LOADR, 0);
    go(`TIE_OP_MOVE);
    check(lastSel, `TIE_REG_HIADR);
    check({lastWord, lastData}, {1'b1, 16'h0080});
    check(lastFlags, 8'h45);
    prep(`TIE_FMT_Q, 1'b1, `TIE_OPD_IMM, 3'h0, `TIE_OPD_REG, `TIE_REG_ACC_LO, 20'h00008);
    go(`TIE_OP_MOVE);
    check(lastData, 16'hfff8);
    prep(`TIE_FMT_Q, 1'b1, `TIE_OPD_IMM, 3'h0, `TIE_OPD_REG, `TIE_REG_ACC_LO, 20'h00007);
    go(`TIE_OP_MOVE);
    check(lastData, 16'h0007);
    check(lastFlags, 8'h45);
    $display("test moves done");
  endtask

  // Every extended source kind, plus a byte into the low address register
  task automatic t_ext;
    logic [2:0]  kinds [3] = '{`TIE_OPD_DSP20, `TIE_OPD_ABSOLUTE_LONG_ADDRESS, `TIE_OPD_PAIR};
    logic [19:0] addrs [3] = '{20'h15678, 20'h3a5c3, 20'h25678};
    hiAddrRegData <= 16'h0002;
    loAddrRegData <= 16'h5678;
    for (int i = 0; i < 3; i++)
    begin
      prep(`TIE_FMT_G, 1'b1, kinds[i], 3'h0, `TIE_OPD_REG, `TIE_REG_ACC_LO,
           i == 0 ? 20'h10000 : addrs[i]);
      go(`TIE_OP_EXTLOAD);
      check(lastAddr, addrs[i]);
      check(lastData, addrs[i][15:0] ^ 16'h3c3c);
    end
    prep(`TIE_FMT_G, 1'b0, `TIE_OPD_ABSOLUTE_LONG_ADDRESS, 3'h0, `TIE_OPD_REG, `TIE_REG_LOADR, 20'h1013c);
    go(`TIE_OP_EXTLOAD);
    check({lastWord, lastData}, {1'b1, 16'h0000});
    check(lastFlags, 8'h47);
    $display("test extended loads done");
  endtask

  // Task 3, selection a5 restores four registers, correction of 8 bytes
  task automatic t_ctx;
    memTab[20'h00200] = 16'h0003;
    memTab[20'h08006] = 16'h08a5;
    memTab[20'h08007] = 16'h0008;
    watchAddr <= 20'h08006;
    prep(`TIE_FMT_G, 1'b1, `TIE_OPD_ABSOLUTE_LONG_ADDRESS, 3'h0, `TIE_OPD_REG, 3'h0, 20'h08000);
    operandB  <= 16'h0200;
    go(`TIE_OP_CTX);
    check(sawAddr, 1'b1);
    check(nReg, 4);
    check(lastSp, 16'h0408);
    check(lastFlags, flagsIn);
    $display("test context restore done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_ctl();
    t_move();
    t_ext();
    t_ctx();
    report_and_stop();
  end

  initial
  begin
    #(40 * 20000);
    err_total++;
    report_and_stop();
  end
endmodule // tb_top

bind tie_exec tie_exec_sva u_tie_exec_sva (.clk, .reset_n, .start, .opCode, .sizeWord,
  .operandA, .operandB, .flagsIn, .regWrite, .regSel, .regWdata, .regWordWrite, .spWrite,
  .vectorTableBase, .interruptPriorityLevel, .flagsWrite, .flagsOut, .busy);
`default_nettype wire
